// ===== common/sper_pkg.sv
// package for the switch port error reporting register bank
package sper_pkg;
   // register byte addresses
   localparam logic [11:0] SPER_PARITY_CTL_ADDR  = 12'h744;
   localparam logic [11:0] SPER_PARITY_RPT_ADDR  = 12'h748;
   localparam logic [11:0] SPER_PARITY_CNT_ADDR  = 12'h74C;
   localparam logic [11:0] SPER_TO_CTL_ADDR      = 12'h750;
   localparam logic [11:0] SPER_TO_STS_ADDR      = 12'h754;
   localparam logic [11:0] SPER_TO_RPT_ADDR      = 12'h758;
   // field widths and reset values
   localparam int          SPER_SEV_W            = 2;
   localparam int          SPER_NQ               = 4;
   localparam logic [1:0]  SPER_PAR_SEV_RST      = 2'h2;
   localparam logic [7:0]  SPER_TO_RPT_RST       = 8'h82;
   localparam logic [7:0]  SPER_CNT_MAX          = 8'hFF;
   localparam logic [7:0]  SPER_CNT_RST          = 8'h00;
   localparam int          SPER_TO_EN_BIT        = 0;
   localparam int          SPER_FLAG_BIT         = 0;
   // bus responses
   localparam logic [1:0]  SPER_RESP_OKAY        = 2'h0;
   localparam logic [1:0]  SPER_RESP_SLVERR      = 2'h2;

   // message severities toward the root
   typedef enum logic [1:0] {
      SPER_SEV_NONE,
      SPER_SEV_COR,
      SPER_SEV_NONFATAL,
      SPER_SEV_FATAL
   } sper_sev_t;

   // one error message request
   typedef struct packed {
      logic       valid;
      sper_sev_t  sev;
   } sper_msg_t;
endpackage

// ===== rtl/sper_regs.sv
// switch port error reporting register bank with an AXI4-Lite slave
// Notes on behaviour
// - parity severity 0 none, 1 correctable, 2 nonfatal; resets to 2.
// - parity message only when the parity flag rises from zero to one.
// - eight-bit parity tally counts errors, saturates at 0xFF, resets to zero.
// - reading the parity tally returns its value and clears it.
// - timeout enable bit 0, reset 0, lets stale queued packets be discarded.
// - status bits 0 posted, 1 nonposted set on discard; write one clears.
// - status bits 2 completion, 3 inserted set on discard; write one clears.
// - posted severity bits 1:0, reset 2; none, cor, nonfatal, fatal.
// - nonposted severity bits 3:2, reset 0, same encoding.
// - completion severity bits 5:4, reset 0, same encoding.
// - inserted severity bits 7:6, reset 2, same encoding.
// - each queue message only when its status bit rises.
// - parity flag sets on each parity error; write one clears.
`timescale 1ns/100ps
module sper_regs
   import sper_pkg::*;
(
   input  wire logic              ref_clk,         // core clock, 40 MHz
   input  wire logic              rst_n,           // async reset, active low
   // axi4-lite slave
   input  wire logic [11:0]       s_axi_awaddr,    // write address
   input  wire logic              s_axi_awvalid,   // write address valid
   output logic                   s_axi_awready,   // write address ready
   input  wire logic [31:0]       s_axi_wdata,     // write data
   input  wire logic [3:0]        s_axi_wstrb,     // write strobes
   input  wire logic              s_axi_wvalid,    // write data valid
   output logic                   s_axi_wready,    // write data ready
   output logic [1:0]             s_axi_bresp,     // write response
   output logic                   s_axi_bvalid,    // write response valid
   input  wire logic              s_axi_bready,    // write response ready
   input  wire logic [11:0]       s_axi_araddr,    // read address
   input  wire logic              s_axi_arvalid,   // read address valid
   output logic                   s_axi_arready,   // read address ready
   output logic [31:0]            s_axi_rdata,     // read data
   output logic [1:0]             s_axi_rresp,     // read response
   output logic                   s_axi_rvalid,    // read data valid
   input  wire logic              s_axi_rready,    // read data ready
   // port events
   input  wire logic              parity_err,      // one pulse per parity error
   input  wire logic [SPER_NQ-1:0] queue_discard,  // discard pulses p, np, cpl, ins
   output logic                   timeout_enable_bit, // lets queues discard stale packets
   // messages toward the root
   output sper_msg_t              parity_msg,      // parity error message, pulse
   output sper_msg_t              timeout_msg,     // queue timeout message, pulse
   output logic [SPER_NQ-1:0]     timeout_msg_src  // queues behind timeout_msg
);

   // write channel state
   logic              aw_have_q, aw_have_d;
   logic              w_have_q, w_have_d;
   logic [11:0]       aw_addr_q, aw_addr_d;
   logic [31:0]       w_data_q, w_data_d;
   logic [3:0]        w_strb_q, w_strb_d;
   logic              bvalid_q, bvalid_d;
   logic [1:0]        bresp_q, bresp_d;
   // read channel state
   logic              rvalid_q, rvalid_d;
   logic [31:0]       rdata_q, rdata_d;
   logic [1:0]        rresp_q, rresp_d;
   // register state
   sper_sev_t         par_sev_q, par_sev_d;
   logic [7:0]        parity_error_tally_q, parity_error_tally_d;
   logic              parity_error_flag_q, parity_error_flag_d;
   logic              to_en_q, to_en_d;
   logic [SPER_NQ-1:0] to_sts_q, to_sts_d;
   logic [7:0]        to_rpt_q, to_rpt_d;
   sper_msg_t         parity_msg_q, parity_msg_d;
   sper_msg_t         timeout_msg_q, timeout_msg_d;
   logic [SPER_NQ-1:0] msg_src_q, msg_src_d;

   logic              wr_fire, rd_fire;
   logic [SPER_NQ-1:0] to_rise;
   sper_sev_t         worst;

   // handshakes: take address and data separately, answer once both held
   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready  = !w_have_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;
   assign rd_fire       = s_axi_arvalid && s_axi_arready;

   // next state for bus and registers
   always_comb
   begin
      aw_have_d            = aw_have_q;
      w_have_d             = w_have_q;
      aw_addr_d            = aw_addr_q;
      w_data_d             = w_data_q;
      w_strb_d             = w_strb_q;
      bvalid_d             = bvalid_q;
      bresp_d              = bresp_q;
      rvalid_d             = rvalid_q;
      rdata_d              = rdata_q;
      rresp_d              = rresp_q;
      par_sev_d            = par_sev_q;
      parity_error_tally_d = parity_error_tally_q;
      parity_error_flag_d  = parity_error_flag_q;
      to_en_d              = to_en_q;
      to_sts_d             = to_sts_q;
      to_rpt_d             = to_rpt_q;
      if (s_axi_awvalid && s_axi_awready)
      begin
         aw_have_d = 1'b1;
         aw_addr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         w_have_d = 1'b1;
         w_data_d = s_axi_wdata;
         w_strb_d = s_axi_wstrb;
      end
      if (bvalid_q && s_axi_bready)
         bvalid_d = 1'b0;
      if (rvalid_q && s_axi_rready)
         rvalid_d = 1'b0;
      // register writes, low byte lane carries every field
      if (wr_fire)
      begin
         aw_have_d = 1'b0;
         w_have_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = SPER_RESP_OKAY;
         case ({aw_addr_q[11:2], 2'b00})
            SPER_PARITY_CTL_ADDR:
               if (w_strb_q[0] && w_data_q[SPER_FLAG_BIT])
                  parity_error_flag_d = 1'b0;
            SPER_PARITY_RPT_ADDR:
               if (w_strb_q[0])
                  par_sev_d = sper_sev_t'(w_data_q[1:0]);
            SPER_PARITY_CNT_ADDR: ;
            SPER_TO_CTL_ADDR:
               if (w_strb_q[0])
                  to_en_d = w_data_q[SPER_TO_EN_BIT];
            SPER_TO_STS_ADDR:
               if (w_strb_q[0])
                  to_sts_d = to_sts_q & ~w_data_q[SPER_NQ-1:0];
            SPER_TO_RPT_ADDR:
               if (w_strb_q[0])
                  to_rpt_d = w_data_q[7:0];
            default:
               bresp_d = SPER_RESP_SLVERR;
         endcase
      end
      // register reads
      if (rd_fire)
      begin
         rvalid_d = 1'b1;
         rresp_d  = SPER_RESP_OKAY;
         rdata_d  = 32'h0000_0000;
         case ({s_axi_araddr[11:2], 2'b00})
            SPER_PARITY_CTL_ADDR: rdata_d[SPER_FLAG_BIT] = parity_error_flag_q;
            SPER_PARITY_RPT_ADDR: rdata_d[1:0] = par_sev_q;
            SPER_PARITY_CNT_ADDR:
            begin
               rdata_d[7:0]         = parity_error_tally_q;
               parity_error_tally_d = SPER_CNT_RST;
            end
            SPER_TO_CTL_ADDR:     rdata_d[SPER_TO_EN_BIT] = to_en_q;
            SPER_TO_STS_ADDR:     rdata_d[SPER_NQ-1:0] = to_sts_q;
            SPER_TO_RPT_ADDR:     rdata_d[7:0] = to_rpt_q;
            default:              rresp_d = SPER_RESP_SLVERR;
         endcase
      end
      // hardware events win over software clears
      if (parity_err)
      begin
         parity_error_flag_d = 1'b1;
         // an error that meets the clearing read is the first of the new count
         if (rd_fire && s_axi_araddr[11:2] == SPER_PARITY_CNT_ADDR[11:2])
            parity_error_tally_d = 8'h01;
         else if (parity_error_tally_q != SPER_CNT_MAX)
            parity_error_tally_d = parity_error_tally_q + 8'h01;
      end
      to_sts_d = to_sts_d | queue_discard;
   end

   // rising status bits and parity message choice
   assign to_rise = to_sts_d & ~to_sts_q;

   always_comb
   begin
      parity_msg_d       = '0;
      timeout_msg_d      = '0;
      msg_src_d          = '0;
      worst              = SPER_SEV_NONE;
      if (parity_error_flag_d && !parity_error_flag_q)
      begin
         case (par_sev_q)
            SPER_SEV_COR:      parity_msg_d = '{valid: 1'b1, sev: SPER_SEV_COR};
            SPER_SEV_NONFATAL: parity_msg_d = '{valid: 1'b1, sev: SPER_SEV_NONFATAL};
            default:           parity_msg_d = '0;
         endcase
      end
      // one message per cycle at the most severe level of the risen queues
      for (int i = 0; i < SPER_NQ; i++)
      begin
         if (to_rise[i] && to_rpt_q[2*i +: 2] != 2'(SPER_SEV_NONE))
         begin
            msg_src_d[i] = 1'b1;
            if (to_rpt_q[2*i +: 2] > 2'(worst))
               worst = sper_sev_t'(to_rpt_q[2*i +: 2]);
         end
      end
      if (worst != SPER_SEV_NONE)
         timeout_msg_d = '{valid: 1'b1, sev: worst};
   end

   // register all state
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_have_q            <= 1'b0;
         w_have_q             <= 1'b0;
         aw_addr_q            <= 12'h000;
         w_data_q             <= 32'h0000_0000;
         w_strb_q             <= 4'h0;
         bvalid_q             <= 1'b0;
         bresp_q              <= SPER_RESP_OKAY;
         rvalid_q             <= 1'b0;
         rdata_q              <= 32'h0000_0000;
         rresp_q              <= SPER_RESP_OKAY;
         par_sev_q            <= sper_sev_t'(SPER_PAR_SEV_RST);
         parity_error_tally_q <= SPER_CNT_RST;
         parity_error_flag_q  <= 1'b0;
         to_en_q              <= 1'b0;
         to_sts_q             <= '0;
         to_rpt_q             <= SPER_TO_RPT_RST;
         parity_msg_q         <= '0;
         timeout_msg_q        <= '0;
         msg_src_q            <= '0;
      end
      else
      begin
         aw_have_q            <= aw_have_d;
         w_have_q             <= w_have_d;
         aw_addr_q            <= aw_addr_d;
         w_data_q             <= w_data_d;
         w_strb_q             <= w_strb_d;
         bvalid_q             <= bvalid_d;
         bresp_q              <= bresp_d;
         rvalid_q             <= rvalid_d;
         rdata_q              <= rdata_d;
         rresp_q              <= rresp_d;
         par_sev_q            <= par_sev_d;
         parity_error_tally_q <= parity_error_tally_d;
         parity_error_flag_q  <= parity_error_flag_d;
         to_en_q              <= to_en_d;
         to_sts_q             <= to_sts_d;
         to_rpt_q             <= to_rpt_d;
         parity_msg_q         <= parity_msg_d;
         timeout_msg_q        <= timeout_msg_d;
         msg_src_q            <= msg_src_d;
      end
   end

   // outputs
   assign s_axi_bvalid       = bvalid_q;
   assign s_axi_bresp        = bresp_q;
   assign s_axi_rvalid       = rvalid_q;
   assign s_axi_rdata        = rdata_q;
   assign s_axi_rresp        = rresp_q;
   assign timeout_enable_bit = to_en_q;
   assign parity_msg         = parity_msg_q;
   assign timeout_msg        = timeout_msg_q;
   assign timeout_msg_src    = msg_src_q;

   // checks on counter, flags and messages
   property p_cnt_sat;
      @(posedge ref_clk) disable iff (!rst_n)
      (parity_error_tally_q == SPER_CNT_MAX && !rd_fire) |=> parity_error_tally_q == SPER_CNT_MAX;
   endproperty
   a_cnt_sat: assert property (p_cnt_sat) else $error("tally left saturation");

   property p_cnt_inc;
      @(posedge ref_clk) disable iff (!rst_n)
      (parity_err && !rd_fire && parity_error_tally_q != SPER_CNT_MAX)
      |=> parity_error_tally_q == $past(parity_error_tally_q) + 8'h01;
   endproperty
   a_cnt_inc: assert property (p_cnt_inc) else $error("tally did not count");

   property p_cnt_rc;
      @(posedge ref_clk) disable iff (!rst_n)
      (rd_fire && s_axi_araddr == SPER_PARITY_CNT_ADDR && !parity_err)
      |=> parity_error_tally_q == 8'h00 && rdata_q[7:0] == $past(parity_error_tally_q);
   endproperty
   a_cnt_rc: assert property (p_cnt_rc) else $error("tally read did not clear");

   property p_cnt_both;
      @(posedge ref_clk) disable iff (!rst_n)
      (rd_fire && {s_axi_araddr[11:2], 2'b00} == SPER_PARITY_CNT_ADDR && parity_err)
      |=> parity_error_tally_q == 8'h01;
   endproperty
   a_cnt_both: assert property (p_cnt_both) else $error("tally lost error during read");

   property p_par_msg;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(parity_error_flag_q) |-> parity_msg_q.valid == ($past(par_sev_q) inside
         {SPER_SEV_COR, SPER_SEV_NONFATAL});
   endproperty
   a_par_msg: assert property (p_par_msg) else $error("parity message mismatch");

   property p_par_once;
      @(posedge ref_clk) disable iff (!rst_n)
      parity_msg_q.valid |-> $rose(parity_error_flag_q) && parity_msg_q.sev != SPER_SEV_FATAL;
   endproperty
   a_par_once: assert property (p_par_once) else $error("parity message without rise");

   property p_flag_set;
      @(posedge ref_clk) disable iff (!rst_n)
      parity_err |=> parity_error_flag_q;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("parity flag not set");

   property p_sts_set;
      @(posedge ref_clk) disable iff (!rst_n)
      queue_discard[0] |=> to_sts_q[0];
   endproperty
   a_sts_set: assert property (p_sts_set) else $error("posted status not set");

   property p_sts_ins;
      @(posedge ref_clk) disable iff (!rst_n)
      queue_discard[3] |=> to_sts_q[3];
   endproperty
   a_sts_ins: assert property (p_sts_ins) else $error("inserted status not set");

   property p_to_msg;
      @(posedge ref_clk) disable iff (!rst_n)
      timeout_msg_q.valid |-> (timeout_msg_src & ~$past(to_sts_q)) == timeout_msg_src
         && timeout_msg_src != '0;
   endproperty
   a_to_msg: assert property (p_to_msg) else $error("timeout message without rise");

   property p_en;
      @(posedge ref_clk) disable iff (!rst_n)
      (wr_fire && {aw_addr_q[11:2], 2'b00} == SPER_TO_CTL_ADDR && w_strb_q[0])
      |=> timeout_enable_bit == $past(w_data_q[SPER_TO_EN_BIT]);
   endproperty
   a_en: assert property (p_en) else $error("enable output diverged");

endmodule // sper_regs

// ===== testbench/sper_root_model.sv
// root complex stand-in that counts the error messages it receives
`timescale 1ns/100ps
module sper_root_model
   import sper_pkg::*;
(
   input  wire logic       ref_clk,         // core clock
   input  wire logic       rst_n,           // async reset, active low
   input  wire sper_msg_t  parity_msg,      // parity message
   input  wire sper_msg_t  timeout_msg,     // timeout message
   input  wire logic [3:0] timeout_msg_src, // queues behind it
   output int              n_par,           // parity messages seen
   output logic [1:0]      last_par,        // last parity severity
   output int              n_to,            // timeout messages seen
   output logic [5:0]      last_to          // last timeout severity and queues
);
   // take every message at once, the root never stalls
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         n_par    <= 0;
         last_par <= 2'h0;
         n_to     <= 0;
         last_to  <= 6'h00;
      end
      else
      begin
         if (parity_msg.valid)
         begin
            n_par    <= n_par + 1;
            last_par <= parity_msg.sev;
         end
         if (timeout_msg.valid)
         begin
            n_to    <= n_to + 1;
            last_to <= {timeout_msg.sev, timeout_msg_src};
         end
      end
   end
endmodule // sper_root_model

// ===== testbench/tb_top.sv
// self-checking bench for the switch port error reporting register bank
`timescale 1ns/100ps
module tb_top;
   import sper_pkg::*;
   logic        ref_clk = 1'b0, rst_n = 1'b0, m_flag = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata, rnd = 32'h1FCBD87E;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
   logic        rready = 1'b0, parity_err = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, timeout_enable_bit;
   logic [3:0]  queue_discard = 4'h0, m_sts = 4'h0, timeout_msg_src;
   logic [1:0]  bresp, rresp, last_par, m_lastp = 2'h0;
   logic [5:0]  last_to, m_lastt = 6'h00;
   logic [7:0]  m_rpt;
   sper_msg_t   parity_msg, timeout_msg;
   int          n_par, n_to, m_tally = 0, m_psev = 2, m_npar = 0, m_nto = 0;
   int          n_mismatch = 0, n_compared = 0;
   int          tn[3] = '{254, 255, 256};

   sper_regs dut (.ref_clk(ref_clk), .rst_n(rst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .parity_err(parity_err), .queue_discard(queue_discard),
      .timeout_enable_bit(timeout_enable_bit), .parity_msg(parity_msg),
      .timeout_msg(timeout_msg), .timeout_msg_src(timeout_msg_src));

   sper_root_model root (.ref_clk(ref_clk), .rst_n(rst_n), .parity_msg(parity_msg),
      .timeout_msg(timeout_msg), .timeout_msg_src(timeout_msg_src), .n_par(n_par),
      .last_par(last_par), .n_to(n_to), .last_to(last_to));

   // 40 MHz core clock
   always #12.5 ref_clk = ~ref_clk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // both channels offered together, each released when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] e);
      logic ta, tw;
      @(posedge ref_clk);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      forever
      begin
         @(negedge ref_clk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         if (bvalid & bready)
            break;
         @(posedge ref_clk);
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
      end
      chk($sformatf("bresp %h", a), {30'h0, bresp}, {30'h0, e});
      @(posedge ref_clk);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta;
      @(posedge ref_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      forever
      begin
         @(negedge ref_clk);
         ta = arvalid & arready;
         if (rvalid & rready)
            break;
         @(posedge ref_clk);
         if (ta)
            arvalid <= 1'b0;
      end
      d = rdata;
      r = rresp;
      @(posedge ref_clk);
      rready <= 1'b0;
   endtask

   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk($sformatf("rdata %h", a), d, e);
      chk($sformatf("rresp %h", a), {30'h0, r}, {30'h0, SPER_RESP_OKAY});
   endtask

   // n parity error cycles or one discard pulse, then model update and compare
   task automatic ev(input int n, input logic [3:0] q);
      logic [1:0] s;
      @(posedge ref_clk);
      parity_err    <= (n > 0);
      queue_discard <= q;
      repeat ((n > 0) ? n : 1) @(posedge ref_clk);
      parity_err    <= 1'b0;
      queue_discard <= 4'h0;
      repeat (3) @(posedge ref_clk);
      if (n > 0)
      begin
         m_tally = (m_tally + n > 255) ? 255 : m_tally + n;
         if (!m_flag && (m_psev == 1 || m_psev == 2))
         begin
            m_npar++;
            m_lastp = m_psev[1:0];
         end
         m_flag = 1'b1;
      end
      for (int i = 0; i < 4; i++)
         if (q[i])
         begin
            s = m_rpt[2*i +: 2];
            if (!m_sts[i] && s != 2'h0)
            begin
               m_nto++;
               m_lastt = {s, 4'h1 << i};
            end
            m_sts[i] = 1'b1;
         end
      chk("parity msgs", n_par, m_npar);
      chk("parity sev", {30'h0, last_par}, {30'h0, m_lastp});
      chk("timeout msgs", n_to, m_nto);
      chk("timeout msg", {26'h0, last_to}, {26'h0, m_lastt});
      rc(SPER_PARITY_CTL_ADDR, {31'h0, m_flag});
      rc(SPER_TO_STS_ADDR, {28'h0, m_sts});
   endtask

   task automatic summarize();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // cut a hang short
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      summarize();
   end

   // main sequence
   initial
   begin
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      rc(SPER_PARITY_RPT_ADDR, 32'h2);
      rc(SPER_PARITY_CNT_ADDR, 32'h0);
      rc(SPER_TO_CTL_ADDR, 32'h0);
      rc(SPER_TO_STS_ADDR, 32'h0);
      rc(SPER_TO_RPT_ADDR, 32'h82);
      wr(12'h7F0, rnd, SPER_RESP_SLVERR);
      ev(1, 4'h0);
      for (int s = 0; s < 4; s++)
      begin
         rnd = lfsr(rnd);
         wr(SPER_PARITY_RPT_ADDR, {rnd[31:2], 2'(s)}, SPER_RESP_OKAY);
         m_psev = s;
         rc(SPER_PARITY_RPT_ADDR, s);
         wr(SPER_PARITY_CTL_ADDR, {rnd[31:1], 1'b1}, SPER_RESP_OKAY);
         m_flag = 1'b0;
         ev(1 + rnd[1:0], 4'h0);
         ev(1, 4'h0);
      end
      rc(SPER_PARITY_CNT_ADDR, m_tally);
      foreach (tn[k])
      begin
         ev(tn[k], 4'h0);
         rc(SPER_PARITY_CNT_ADDR, 255 < tn[k] ? 255 : tn[k]);
      end
      rc(SPER_PARITY_CNT_ADDR, 32'h0);
      // an error in the very cycle of a clearing read leaves a count of one
      ev(2, 4'h0);
      fork
         rc(SPER_PARITY_CNT_ADDR, 32'h2);
         begin
            @(posedge ref_clk);
            parity_err <= 1'b1;
            @(posedge ref_clk);
            parity_err <= 1'b0;
         end
      join
      rc(SPER_PARITY_CNT_ADDR, 32'h1);
      for (int b = 0; b < 2; b++)
      begin
         rnd = lfsr(rnd);
         wr(SPER_TO_CTL_ADDR, {rnd[31:1], 1'(b)}, SPER_RESP_OKAY);
         rc(SPER_TO_CTL_ADDR, b);
         chk("enable", {31'h0, timeout_enable_bit}, b);
      end
      for (int i = 0; i < 12; i++)
      begin
         rnd = lfsr(rnd);
         m_rpt = rnd[7:0];
         wr(SPER_TO_RPT_ADDR, rnd, SPER_RESP_OKAY);
         rc(SPER_TO_RPT_ADDR, m_rpt);
         ev(0, 4'h1 << (i % 4));
         ev(0, 4'h1 << (i % 4));
         wr(SPER_TO_STS_ADDR, rnd >> 8, SPER_RESP_OKAY);
         m_sts = m_sts & ~rnd[11:8];
         rc(SPER_TO_STS_ADDR, m_sts);
      end
      summarize();
   end
endmodule // tb_top
